// ---- rtl/twb_regs.svh ----
// Purpose: constants for the two-wire slave bus front end
// Assumes: ref clock 25 MHz, link sample clock 64 ns period
// Notes: the types live in twb_pkg
// Operation
// - Ignore the bus until power-on reset is released, then enter standby.
// - Sample SDA on SCL rising edge; change driven SDA only after falling edge.
// - Every byte is shifted most significant bit first, one bit per clock.
// - Each byte takes nine clocks: eight data, ninth carries ACK or NACK.
// - SDA changes only while SCL is low and stays stable while high.
// - SDA falling while SCL high is a start and leaves standby.
// - Every command opens with a start; stay silent until one is seen.
// - SDA rising while SCL high is a stop and ends the transfer.
// - A repeated start begins a new command instead of a stop.
// - The bus is idle only while SCL and SDA are both high.
// - The host decides byte count between start and stop; no limit.
// - Transmitter releases SDA after eighth fall; receiver holds low in ninth.
// - Receiver releases SDA at the end of the ninth clock.
// - When host leaves SDA high in ninth clock, release SDA for stop.
// - Standby after power-up, after write cycle, and after stop.
// - After interruption, release SDA once further clocks finish the driven byte.
// - SDA is open drain only: pull low or release, never drive high.
// - SCL is an input only, never driven or stretched.
// - Acknowledge a matching address byte, stay silent on a mismatch.
// - During an internal write cycle leave the address acknowledge released.
`ifndef TWB_REGS_SVH
`define TWB_REGS_SVH
`define TWB_REF_CLK_NS 40
`define TWB_LINK_CLK_NS 64
`define TWB_SPIKE_NS 100
`define TWB_FILT_CYC ((`TWB_SPIKE_NS + `TWB_LINK_CLK_NS - 1) / `TWB_LINK_CLK_NS)
`define TWB_HOST_STARTUP_WAIT_US 100
`define TWB_HOST_STARTUP_WAIT_CYC ((`TWB_HOST_STARTUP_WAIT_US * 1000 + `TWB_REF_CLK_NS - 1) / `TWB_REF_CLK_NS)
`define TWB_DEV_TYPE 4'hA
`define TWB_BITS_PER_BYTE 4'h8
`define TWB_EV_RX 0
`define TWB_EV_START 1
`define TWB_EV_STOP 2
`define TWB_EV_TAKE 3
`define TWB_EV_N 4
`endif

// ---- rtl/twb_pkg.sv ----
// Purpose: types shared by the two-wire slave front end
// Assumes: nothing beyond the header constants
// Notes: bus_t keeps scl in the upper bit
`default_nettype none
package twb_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK} lnk_state_t;
    typedef struct packed {
        logic is_addr;
        byte_t data;
    } rx_word_t;
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_t;
endpackage
`default_nettype wire

// ---- rtl/twb_deglitch.sv ----
// Purpose: two-flop synchroniser and spike filter per line
// Assumes: lines idle high
// Notes: a new level must stand LEN cycles before it is passed on
`include "twb_regs.svh"
`default_nettype none
module twb_deglitch #(
    parameter int W = 2,
    parameter int LEN = `TWB_FILT_CYC
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] raw_in,
    output logic [W-1:0] clean_out
);
    localparam int CW = $clog2(LEN + 1);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic [CW-1:0] cnt_q;
            logic clean_q;
            // count how long the synced level differs from the output
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    cnt_q <= '0;
                    clean_q <= 1'b1;
                end else if (sync_q[i] == clean_q) begin
                    cnt_q <= '0;
                end else if (cnt_q == CW'(LEN - 1)) begin
                    cnt_q <= '0;
                    clean_q <= sync_q[i];
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
            assign clean_out[i] = clean_q;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- rtl/two_wire_slave_bus_frontend.sv ----
// Purpose: slave bit and byte layer of a two-wire serial memory port
// Assumes: link_clk_in oversamples SCL; user side runs on ref_clk_in
// Notes: SCL is only ever an input; SDA is open drain
`include "twb_regs.svh"
`default_nettype none
module two_wire_slave_bus_frontend #(
    parameter logic [3:0] DEV_TYPE = `TWB_DEV_TYPE,
    parameter int FILT_LEN = `TWB_FILT_CYC
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic link_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [1:0] addr_pins_in,
    input wire logic wr_busy_in,
    input wire logic ack_data_in,
    input wire twb_pkg::byte_t tx_byte_in,
    input wire logic tx_load_in,
    output twb_pkg::byte_t rx_byte_out,
    output logic rx_is_addr_out,
    output logic rx_valid_out,
    output logic start_out,
    output logic stop_out,
    output logic tx_req_out,
    output logic standby_out,
    output logic bus_idle_out
);
    import twb_pkg::*;

    // link side reset and sampling
    logic [1:0] lrst_q;
    logic lrst_n;
    bus_t raw;
    bus_t flt;
    bus_t prev_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // link side control
    lnk_state_t state_q;
    logic [3:0] bit_cnt_q;
    byte_t sh_q;
    logic is_addr_q;
    logic rd_mode_q;
    logic oe_q;
    logic sda_q;
    logic addr_ok;
    rx_word_t rx_word_q;
    logic [`TWB_EV_N-1:0] ev_hit;
    logic [`TWB_EV_N-1:0] ev_tgl_q;
    logic [1:0] lvl_q;

    // inputs crossing into the link side
    logic [1:0] pin_meta_q;
    logic [1:0] pin_q;
    logic [1:0] ctl_meta_q;
    logic [1:0] ctl_q;
    logic [2:0] txt_q;
    byte_t tx_buf_q;

    // user side
    logic [1:0] ctl_ref_q;
    byte_t tx_hold_q;
    logic tx_tgl_q;
    logic [`TWB_EV_N-1:0] ev_pls;
    logic [`TWB_EV_N-1:0] ev_out_q;
    rx_word_t rx_out_q;
    logic [1:0] lvl_meta_q;
    logic [1:0] lvl_sync_q;

    // hold the link side in reset until power-on reset is released
    always_ff @(posedge link_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lrst_q <= 2'h0;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end
    assign lrst_n = lrst_q[1];

    // both lines pass synchroniser and spike filter before use
    assign raw = {scl_in, sda_in};
    twb_deglitch #(
        .W(2),
        .LEN(FILT_LEN)
    ) u_deglitch (
        .clk_in(link_clk_in),
        .nrst_in(lrst_n),
        .raw_in(raw),
        .clean_out(flt)
    );

    // previous filtered levels for edge detection
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            prev_q <= 2'h3;
        end else begin
            prev_q <= flt;
        end
    end

    // edges and bus conditions, SDA moving while SCL stays high
    assign scl_rise = flt.scl & ~prev_q.scl;
    assign scl_fall = ~flt.scl & prev_q.scl;
    assign start_det = flt.scl & prev_q.scl & prev_q.sda & ~flt.sda;
    assign stop_det = flt.scl & prev_q.scl & ~prev_q.sda & flt.sda;

    // address pins, control levels and the transmit toggle cross in
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            pin_meta_q <= 2'h0;
            pin_q <= 2'h0;
            ctl_meta_q <= 2'h0;
            ctl_q <= 2'h0;
            txt_q <= 3'h0;
        end else begin
            pin_meta_q <= addr_pins_in;
            pin_q <= pin_meta_q;
            ctl_meta_q <= ctl_ref_q;
            ctl_q <= ctl_meta_q;
            txt_q <= {txt_q[1:0], tx_tgl_q};
        end
    end

    // take the held transmit byte once its toggle has settled
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            tx_buf_q <= 8'hFF;
        end else if (txt_q[2] ^ txt_q[1]) begin
            tx_buf_q <= tx_hold_q;
        end
    end

    // address compare; a busy write cycle refuses the address
    assign addr_ok = (sh_q[7:4] == DEV_TYPE) && (sh_q[3:2] == pin_q)
        && !ctl_q[1];

    // byte engine: start and stop take priority over every state
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            state_q <= S_IDLE;
            bit_cnt_q <= 4'h0;
            sh_q <= 8'h00;
            is_addr_q <= 1'b0;
            rd_mode_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (start_det) begin
            state_q <= S_RX;
            bit_cnt_q <= 4'h0;
            is_addr_q <= 1'b1;
            rd_mode_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= S_IDLE;
            oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    oe_q <= 1'b0;
                end
                S_RX: begin
                    if (scl_rise && bit_cnt_q != `TWB_BITS_PER_BYTE) begin
                        sh_q <= {sh_q[6:0], flt.sda};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == `TWB_BITS_PER_BYTE) begin
                        is_addr_q <= 1'b0;
                        if (is_addr_q && !addr_ok) begin
                            state_q <= S_IDLE;
                        end else begin
                            state_q <= S_ACK;
                            oe_q <= is_addr_q | ctl_q[0];
                            if (is_addr_q) begin
                                rd_mode_q <= sh_q[0];
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall && rd_mode_q) begin
                        state_q <= S_TX;
                        sh_q <= tx_buf_q;
                        oe_q <= ~tx_buf_q[7];
                        bit_cnt_q <= 4'h1;
                    end else if (scl_fall) begin
                        state_q <= S_RX;
                        oe_q <= 1'b0;
                        bit_cnt_q <= 4'h0;
                    end
                end
                S_TX: begin
                    if (scl_fall && bit_cnt_q == `TWB_BITS_PER_BYTE) begin
                        state_q <= S_TXACK;
                        oe_q <= 1'b0;
                    end else if (scl_fall) begin
                        oe_q <= ~sh_q[6];
                        sh_q <= {sh_q[6:0], 1'b1};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
                S_TXACK: begin
                    if (scl_rise) begin
                        state_q <= flt.sda ? S_IDLE : S_ACK;
                    end
                end
            endcase
        end
    end

    // the pin is only ever pulled low, never driven high
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            sda_q <= 1'b0;
        end else begin
            sda_q <= 1'b0;
        end
    end
    assign sda_out = sda_q;
    assign sda_oe_out = oe_q;

    // events for the user side, each as a toggle
    assign ev_hit[`TWB_EV_RX] = !start_det && !stop_det && state_q == S_RX
        && scl_fall && bit_cnt_q == `TWB_BITS_PER_BYTE;
    assign ev_hit[`TWB_EV_START] = start_det;
    assign ev_hit[`TWB_EV_STOP] = stop_det;
    assign ev_hit[`TWB_EV_TAKE] = !start_det && !stop_det && state_q == S_ACK
        && scl_fall && rd_mode_q;

    // received word stays put for nine clocks, long after its toggle lands
    always_ff @(posedge link_clk_in or negedge lrst_n) begin
        if (!lrst_n) begin
            ev_tgl_q <= '0;
            rx_word_q <= '0;
            lvl_q <= 2'h0;
        end else begin
            ev_tgl_q <= ev_tgl_q ^ ev_hit;
            lvl_q <= {state_q == S_IDLE, flt.scl & flt.sda};
            if (ev_hit[`TWB_EV_RX]) begin
                rx_word_q <= '{is_addr: is_addr_q, data: sh_q};
            end
        end
    end

    // user side: registered control levels and the transmit hand-off
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctl_ref_q <= 2'h0;
            tx_hold_q <= 8'hFF;
            tx_tgl_q <= 1'b0;
        end else begin
            ctl_ref_q <= {wr_busy_in, ack_data_in};
            if (tx_load_in) begin
                tx_hold_q <= tx_byte_in;
                tx_tgl_q <= ~tx_tgl_q;
            end
        end
    end

    // each event toggle crosses through its own three flops
    genvar e;
    generate
        for (e = 0; e < `TWB_EV_N; e++) begin : g_ev
            logic [2:0] s_q;
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    s_q <= 3'h0;
                end else begin
                    s_q <= {s_q[1:0], ev_tgl_q[e]};
                end
            end
            assign ev_pls[e] = s_q[2] ^ s_q[1];
        end
    endgenerate

    // one-cycle event pulses and the captured byte
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ev_out_q <= '0;
            rx_out_q <= '0;
        end else begin
            ev_out_q <= ev_pls;
            if (ev_pls[`TWB_EV_RX]) begin
                rx_out_q <= rx_word_q;
            end
        end
    end

    // standby and bus idle levels
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lvl_meta_q <= 2'h0;
            lvl_sync_q <= 2'h0;
        end else begin
            lvl_meta_q <= lvl_q;
            lvl_sync_q <= lvl_meta_q;
        end
    end

    assign rx_byte_out = rx_out_q.data;
    assign rx_is_addr_out = rx_out_q.is_addr;
    assign rx_valid_out = ev_out_q[`TWB_EV_RX];
    assign start_out = ev_out_q[`TWB_EV_START];
    assign stop_out = ev_out_q[`TWB_EV_STOP];
    assign tx_req_out = ev_out_q[`TWB_EV_TAKE];
    assign standby_out = lvl_sync_q[1];
    assign bus_idle_out = lvl_sync_q[0];

    // link side checks, then one user side pulse check
    open_drain_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        sda_out == 1'b0 && !(sda_oe_out && state_q == S_IDLE))
        else $error("sda driven high or pulled in standby");

    start_abort_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        start_det |=> state_q == S_RX && bit_cnt_q == 4'h0 && is_addr_q && !sda_oe_out)
        else $error("start did not restart address byte");

    stop_standby_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        stop_det |=> state_q == S_IDLE && !sda_oe_out)
        else $error("stop did not reach standby");

    fall_change_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        $changed(sda_oe_out) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
        else $error("sda changed without scl fall");

    msb_sample_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        state_q == S_RX && scl_rise && bit_cnt_q != 4'h8 && !start_det && !stop_det
        |=> sh_q[0] == $past(flt.sda) && bit_cnt_q == $past(bit_cnt_q) + 4'h1)
        else $error("bit not shifted in on rise");

    busy_nack_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        state_q == S_RX && scl_fall && bit_cnt_q == 4'h8 && is_addr_q && ctl_q[1]
        && !start_det && !stop_det |=> !sda_oe_out [*2])
        else $error("address acknowledged while busy");

    match_ack_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        state_q == S_RX && scl_fall && bit_cnt_q == 4'h8 && is_addr_q && addr_ok
        && !start_det && !stop_det |=> state_q == S_ACK && sda_oe_out)
        else $error("matching address not acknowledged");

    tx_release_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        state_q == S_TX && scl_fall && bit_cnt_q == 4'h8 && !start_det && !stop_det
        |=> state_q == S_TXACK && !sda_oe_out)
        else $error("sda not released after eighth bit");

    nack_release_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        state_q == S_TXACK && scl_rise && flt.sda && !start_det && !stop_det
        |=> state_q == S_IDLE && !sda_oe_out)
        else $error("sda held after host nack");

    ack_release_a: assert property (
        @(posedge link_clk_in) disable iff (!lrst_n)
        state_q == S_ACK && scl_fall && !rd_mode_q && !start_det && !stop_det
        |=> state_q == S_RX && !sda_oe_out && bit_cnt_q == 4'h0)
        else $error("acknowledge not released");

    pulse_one_a: assert property (
        @(posedge ref_clk_in) disable iff (!nrst_in)
        rx_valid_out |=> !rx_valid_out)
        else $error("byte pulse longer than one cycle");

    // main scenarios
    addr_ack_c: cover property (@(posedge link_clk_in) disable iff (!lrst_n)
        state_q == S_ACK && sda_oe_out && $past(is_addr_q));
    read_nack_c: cover property (@(posedge link_clk_in) disable iff (!lrst_n)
        state_q == S_TXACK && scl_rise && flt.sda);
    rep_start_c: cover property (@(posedge link_clk_in) disable iff (!lrst_n)
        start_det && state_q != S_IDLE);
endmodule
`default_nettype wire

// ---- testbench/twb_host_model.sv ----
// Purpose: behavioural bus master driving SCL and open-drain SDA
// Assumes: wire resolved by the bench with a pull-up; timed on link clock falls
// Notes: tasks are called by the bench; SCL idles high outside frames
`default_nettype none
module twb_host_model (
    input wire logic link_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import twb_pkg::*;
    localparam int Q = 6; // link cycles per quarter bit
    // bus released and idle at time zero
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge link_clk_in);
    endtask
    // one clock: data set in low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        tick(Q);
        sda_oe_out = ~b;
        tick(Q);
        scl_out = 1'b1;
        tick(Q);
        r = sda_in;
        tick(Q);
        scl_out = 1'b0;
    endtask
    task automatic start_cond();
        tick(Q);
        sda_oe_out = 1'b0;
        tick(Q);
        scl_out = 1'b1;
        tick(Q);
        sda_oe_out = 1'b1;
        tick(Q);
        scl_out = 1'b0;
    endtask
    task automatic stop_cond();
        tick(Q);
        sda_oe_out = 1'b1;
        tick(Q);
        scl_out = 1'b1;
        tick(Q);
        sda_oe_out = 1'b0;
        tick(Q);
    endtask
    // eight bits msb first, then a released ninth clock
    task automatic wr_byte(input byte_t d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic ack, output byte_t d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
    // dummy clocks with SDA released until it reads high
    task automatic recover(output int n);
        logic r;
        n = 0;
        r = 1'b0;
        while (r !== 1'b1 && n < 9) begin
            bit_io(1'b1, r);
            n++;
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the two-wire slave front end
// Assumes: host model on the link side, short filter for speed
// Notes: received bytes are checked against a queue of expected words
`include "twb_regs.svh"
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import twb_pkg::*;
    logic ref_clk, link_clk, nrst, scl, host_oe, sda_wire, sda_out, sda_oe;
    logic [1:0] addr_pins;
    logic wr_busy, ack_data, rx_is_addr, rx_valid, start_p, stop_p, tx_req;
    logic standby, bus_idle, ack, preload;
    logic tx_load = 1'b0;
    byte_t tx_byte, rx_byte, d, adr_w, adr_r, adr_bad;
    byte_t txd [3];
    byte_t tx_q [$];
    rx_word_t exp_q [$];
    int n_fail = 0;
    int n_checks = 0;
    int n_start = 0;
    int n_stop = 0;
    int n_take = 0;
    int seed, n;
    // open-drain wire with pull-up
    assign sda_wire = ~(host_oe | sda_oe);
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #32 link_clk = ~link_clk;
    end
    two_wire_slave_bus_frontend #(.FILT_LEN(1)) u_dut (
        .ref_clk_in(ref_clk), .nrst_in(nrst), .link_clk_in(link_clk), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe),
        .addr_pins_in(addr_pins), .wr_busy_in(wr_busy), .ack_data_in(ack_data),
        .tx_byte_in(tx_byte), .tx_load_in(tx_load), .rx_byte_out(rx_byte),
        .rx_is_addr_out(rx_is_addr), .rx_valid_out(rx_valid), .start_out(start_p),
        .stop_out(stop_p), .tx_req_out(tx_req), .standby_out(standby),
        .bus_idle_out(bus_idle)
    );
    twb_host_model u_host (
        .link_clk_in(link_clk), .sda_in(sda_wire), .scl_out(scl), .sda_oe_out(host_oe)
    );
    task automatic test_done();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // received bytes against the oldest expectation, bus events counted
    always @(negedge ref_clk) begin
        rx_word_t w;
        if (start_p === 1'b1) begin
            n_start++;
        end
        if (stop_p === 1'b1) begin
            n_stop++;
        end
        if (tx_req === 1'b1) begin
            n_take++;
        end
        if (rx_valid === 1'b1) begin
            w = 'x;
            if (exp_q.size() > 0) begin
                w = exp_q.pop_front();
            end
            `CHK({rx_is_addr, rx_byte}, w)
        end
    end
    // feeds read bytes: once on request from main, then on each consume pulse
    always @(negedge ref_clk) begin
        if ((tx_req === 1'b1 || preload) && tx_q.size() > 0) begin
            tx_byte = tx_q.pop_front();
            tx_load = 1'b1;
            preload = 1'b0;
        end else begin
            tx_load = 1'b0;
        end
    end
    task automatic wait_ref(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic addr_write(input byte_t a, input logic exp_ack);
        exp_q.push_back({1'b1, a});
        u_host.start_cond();
        u_host.wr_byte(a, ack);
        `CHK(ack, exp_ack)
    endtask
    initial begin
        #2000000;
        n_fail++;
        test_done();
    end
    initial begin
        seed = 50109;
        nrst = 1'b0;
        preload = 1'b0;
        addr_pins = 2'($random(seed));
        wr_busy = 1'b0;
        ack_data = 1'b1;
        tx_byte = 8'h00;
        adr_w = {`TWB_DEV_TYPE, addr_pins, 2'b00};
        adr_r = {`TWB_DEV_TYPE, addr_pins, 2'b01};
        adr_bad = {`TWB_DEV_TYPE ^ 4'h1, addr_pins, 2'b00};
        wait_ref(16);
        `CHK({standby, sda_oe}, 2'b00)
        nrst = 1'b1;
        wait_ref(`TWB_HOST_STARTUP_WAIT_CYC);
        `CHK({standby, bus_idle}, 2'b11)
        // write: address, three acked bytes, one refused, stop
        addr_write(adr_w, 1'b1);
        `CHK({standby, bus_idle}, 2'b00)
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            @(negedge ref_clk) ack_data = (i < 3);
            exp_q.push_back({1'b0, d});
            u_host.wr_byte(d, ack);
            `CHK(ack, ack_data)
        end
        @(negedge ref_clk) ack_data = 1'b1;
        u_host.stop_cond();
        wait_ref(20);
        `CHK({standby, bus_idle}, 2'b11)
        // foreign address then a silent byte
        addr_write(adr_bad, 1'b0);
        u_host.wr_byte(8'h00, ack);
        `CHK(ack, 1'b0)
        u_host.stop_cond();
        // busy with an internal write
        @(negedge ref_clk) wr_busy = 1'b1;
        addr_write(adr_w, 1'b0);
        u_host.stop_cond();
        @(negedge ref_clk) wr_busy = 1'b0;
        // read three bytes, last one refused by the host
        for (int i = 0; i < 3; i++) begin
            txd[i] = 8'($random(seed));
            tx_q.push_back(txd[i]);
        end
        preload = 1'b1;
        wait_ref(20);
        addr_write(adr_r, 1'b1);
        for (int i = 0; i < 3; i++) begin
            u_host.rd_byte(i < 2, d);
            `CHK(d, txd[i])
        end
        wait_ref(20);
        `CHK({standby, sda_oe}, 2'b10)
        u_host.stop_cond();
        // repeated start inside a data byte
        addr_write(adr_w, 1'b1);
        repeat (3) u_host.bit_io(1'b0, ack);
        addr_write(adr_w, 1'b1);
        u_host.stop_cond();
        // interrupted read of a zero byte, then dummy clocks
        tx_q.push_back(8'h00);
        preload = 1'b1;
        wait_ref(20);
        addr_write(adr_r, 1'b1);
        repeat (2) u_host.bit_io(1'b1, ack);
        wait_ref(30);
        `CHK(sda_oe, 1'b1)
        u_host.recover(n);
        `CHK(n, 7)
        addr_write(adr_w, 1'b1);
        u_host.stop_cond();
        wait_ref(20);
        `CHK(sda_out, 1'b0)
        `CHK(32'(exp_q.size()), 32'h0)
        // eight starts, six stops and four consumed read bytes were sent
        `CHK(n_start, 8)
        `CHK(n_stop, 6)
        `CHK(n_take, 4)
        test_done();
    end
endmodule
`default_nettype wire
